// File: core/sdfr_params.svh
// constants of the serial frame receiver
`ifndef SDFR_PARAMS_SVH
`define SDFR_PARAMS_SVH
`define SDFR_WIDE_BITS 24
`define SDFR_NARROW_BITS 16
`define SDFR_CNT_W 5
`define SDFR_CODE_RST 24'h00_0000
`define SDFR_SCLK_MAX_MHZ 50
`endif

// File: core/sdfr_pkg.sv
// types of the serial frame receiver
package sdfr_pkg;
   typedef logic [23:0] sdfr_word_t;
   typedef struct packed {
      logic [23:0] shift;
      logic [4:0] cnt;
      logic done_tog;
      sdfr_word_t word;
      logic seen_tog;
   } sdfr_link_st_t;
   typedef struct packed {
      logic [2:0] tog_sync;
      logic [1:0] fill;
      sdfr_word_t buf0;
      sdfr_word_t buf1;
      sdfr_word_t code;
      logic code_valid;
   } sdfr_core_st_t;
endpackage : sdfr_pkg

// File: core/sdfr_receiver.sv
// serial frame receiver: link shift register, crossing, buffer, output code
`timescale 1ns/1ps
`include "sdfr_params.svh"
module sdfr_receiver #(
   parameter bit WIDE = 1'b1
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_sclk,
   input wire logic i_sync_n,
   input wire logic i_sdata,
   input wire logic i_code_ready,
   output logic o_code_valid,
   output sdfr_pkg::sdfr_word_t o_code,
   output logic o_frame_ready
);
   // ----------------------------------------------------------------
   // link side
   // ----------------------------------------------------------------
   localparam logic [4:0] LAST = WIDE ? 5'(`SDFR_WIDE_BITS - 1) : 5'(`SDFR_NARROW_BITS - 1);
   sdfr_pkg::sdfr_link_st_t lq, ld;
   logic frame_tog_q;
   always_ff @(posedge i_sync_n or negedge i_rst_n) begin
      if (!i_rst_n) begin
         frame_tog_q <= 1'b0;
      end else begin
         frame_tog_q <= ~frame_tog_q;
      end
   end
   always_comb begin
      logic [4:0] cnt_now;
      cnt_now = (lq.seen_tog != frame_tog_q) ? 5'h00 : lq.cnt;
      ld = lq;
      ld.seen_tog = frame_tog_q;
      if (!i_sync_n) begin
         ld.shift = {lq.shift[22:0], i_sdata};
         ld.cnt = cnt_now + 5'h01;
         if (cnt_now == LAST) begin
            ld.word = WIDE ? {lq.shift[22:0], i_sdata} : {8'h00, lq.shift[14:0], i_sdata};
            ld.done_tog = ~lq.done_tog;
            ld.cnt = 5'h1f;
         end else if (cnt_now == 5'h1f) begin
            ld.cnt = cnt_now;
            ld.shift = lq.shift;
         end
      end
   end
   always_ff @(negedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lq <= '{shift: 24'h00_0000, cnt: 5'h00, done_tog: 1'b0, word: `SDFR_CODE_RST,
                 seen_tog: 1'b0};
      end else begin
         lq <= ld;
      end
   end
   // ----------------------------------------------------------------
   // core side
   // ----------------------------------------------------------------
   sdfr_pkg::sdfr_core_st_t cq, cd;
   logic ev;
   logic pop;
   always_comb begin
      cd = cq;
      cd.tog_sync = {cq.tog_sync[1:0], lq.done_tog};
      ev = cq.tog_sync[2] ^ cq.tog_sync[1];
      pop = cq.fill != 2'd0;
      // output register drains the buffer
      if (pop && (!cq.code_valid || i_code_ready)) begin
         cd.code = cq.buf0;
         cd.code_valid = 1'b1;
         cd.buf0 = cq.buf1;
         cd.fill = cq.fill - 2'd1;
      end else if (cq.code_valid && i_code_ready) begin
         cd.code_valid = 1'b0;
      end else begin
         pop = 1'b0;
      end
      if (ev && cd.fill != 2'd2) begin
         if (cd.fill == 2'd0) begin
            cd.buf0 = lq.word;
         end else begin
            cd.buf1 = lq.word;
         end
         cd.fill = cd.fill + 2'd1;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cq <= '{tog_sync: 3'h0, fill: 2'h0, buf0: `SDFR_CODE_RST, buf1: `SDFR_CODE_RST,
                 code: `SDFR_CODE_RST, code_valid: 1'b0};
      end else begin
         cq <= cd;
      end
   end
   assign o_code = cq.code;
   assign o_code_valid = cq.code_valid;
   assign o_frame_ready = cq.fill != 2'd2;
endmodule : sdfr_receiver

// File: test/sdfr_chk.sv
// checker of the serial frame receiver
`timescale 1ns/1ps
module sdfr_chk (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_sync_n,
   input wire logic i_code_ready,
   input wire logic o_code_valid,
   input wire sdfr_pkg::sdfr_word_t o_code,
   input wire logic o_frame_ready
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_idle; i_sync_n [*8] ##0 !o_code_valid; endsequence
   a_code_stands: assert property (o_code_valid && !i_code_ready |=> o_code_valid && $stable(o_code))
      else $error("code left before taken");
   a_code_cause: assert property ($changed(o_code) |-> $rose(o_code_valid) || $past(i_code_ready))
      else $error("code changed without cause");
   a_idle_quiet: assert property (s_idle |=> !o_code_valid)
      else $error("code without frame");
   a_reset_zero: assert property ($rose(i_rst_n) |-> o_code == 24'h00_0000 && o_frame_ready)
      else $error("reset state wrong");
   a_full_valid: assert property (!o_frame_ready |-> o_code_valid)
      else $error("buffer full with no code");
endmodule : sdfr_chk
bind sdfr_receiver sdfr_chk sdfr_chk_i (.i_core_clk, .i_rst_n, .i_sync_n, .i_code_ready,
   .o_code_valid, .o_code, .o_frame_ready);

// File: test/sdfr_host.sv
// host model driving frames on the serial port
`timescale 1ns/1ps
module sdfr_host (
   output logic o_sclk,
   output logic o_sync_n,
   output logic o_sdata
);
   initial {o_sclk, o_sync_n, o_sdata} = 3'b110;
   task automatic send(input logic [23:0] w, input int n);
      o_sync_n = 1'b0;
      for (int k = 23; k > 23 - n; k--) begin
         o_sdata = w[k];
         #80 o_sclk = 1'b0;
         #80 o_sclk = 1'b1;
      end
      #40 o_sync_n = 1'b1;
      o_sdata = ~o_sdata;
      #100;
   endtask : send
endmodule : sdfr_host

// File: test/tb_sdfr_receiver.sv
// testbench of the serial frame receiver
`timescale 1ns/1ps
module tb_sdfr_receiver;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_code_ready = 1'b1;
   logic sclk, sync_n, sdata, o_code_valid, o_frame_ready;
   sdfr_pkg::sdfr_word_t o_code;
   int num_errors = 0;
   int compares = 0;
   logic [23:0] rows [3] = '{24'hA5_C30F, 24'hFF_FFFF, 24'h80_0001};
   sdfr_host sdfr_host_i (.o_sclk(sclk), .o_sync_n(sync_n), .o_sdata(sdata));
   sdfr_receiver sdfr_receiver_i (.i_core_clk, .i_rst_n, .i_sclk(sclk), .i_sync_n(sync_n),
      .i_sdata(sdata), .i_code_ready, .o_code_valid, .o_code, .o_frame_ready);
   always #5 i_core_clk = ~i_core_clk;
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      #1;
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %h %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   initial begin
      #100000 num_errors++;
      stop_test();
   end
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      chk(o_code, 24'h00_0000);
      chk({23'h0, o_code_valid}, 24'h00_0000);
      foreach (rows[k]) begin
         sdfr_host_i.send(rows[k], 24);
         repeat (8) @(posedge i_core_clk);
         chk(o_code, rows[k]);
      end
      sdfr_host_i.send(24'h12_3456, 23);
      repeat (8) @(posedge i_core_clk);
      chk(o_code, rows[2]);
      @(posedge i_core_clk);
      i_code_ready <= 1'b0;
      foreach (rows[k]) sdfr_host_i.send(rows[k], 24);
      repeat (8) @(posedge i_core_clk);
      chk({o_code[23:1], o_frame_ready}, {rows[0][23:1], 1'b0});
      chk({23'h0, o_code_valid}, 24'h00_0001);
      @(posedge i_core_clk);
      i_code_ready <= 1'b1;
      repeat (8) @(posedge i_core_clk);
      chk(o_code, rows[2]);
      stop_test();
   end
endmodule : tb_sdfr_receiver
